// file: rtl/qdac_serial_load.v
// qdac_serial_load.v: serial word receiver, channel latches and output update of a quad 12-bit converter
// assumes serial pins are asynchronous to sys_clk and slower than a quarter of it
`timescale 1ns/1ps
`include "qdac_regs.vh"
module qdac_serial_load (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        chip_select_n,
  input  wire        frame_sync,
  input  wire        serial_clk,
  input  wire        serial_data,
  input  wire        load_outputs_n,
  input  wire        power_down_n,
  output reg  [11:0] channel_a_output,
  output reg  [11:0] channel_b_output,
  output reg  [11:0] channel_c_output,
  output reg  [11:0] channel_d_output,
  output reg  [3:0]  channel_powered,
  output reg  [3:0]  channel_fast,
  output wire        word_overrun
);
  // two-flop synchronisers; stage 1 is read only by stage 2
  reg [4:0] s1_q;
  reg [4:0] s2_q;
  reg       sclk_prev_q;
  reg       fs_prev_q;
  reg       din_prev_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q        <= 5'h1F;
      s2_q        <= 5'h1F;
      sclk_prev_q <= 1'b1;
      fs_prev_q   <= 1'b1;
      din_prev_q  <= 1'b0;
    end else begin
      s1_q        <= {power_down_n, load_outputs_n, serial_data, frame_sync, serial_clk};
      s2_q        <= s1_q;
      sclk_prev_q <= s2_q[0];
      fs_prev_q   <= s2_q[1];
      din_prev_q  <= s2_q[2];
    end
  end

  wire sclk_s   = s2_q[0];
  wire fs_s     = s2_q[1];
  wire load_n_s = s2_q[3];
  wire pd_n_s   = s2_q[4];
  // chip select is sampled with the same depth
  reg  cs1_q;
  reg  cs2_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs1_q <= 1'b1;
      cs2_q <= 1'b1;
    end else begin
      cs1_q <= chip_select_n;
      cs2_q <= cs1_q;
    end
  end

  wire selected  = ~cs2_q;
  wire fs_fall   = fs_prev_q & ~fs_s & selected;
  wire fs_rise   = ~fs_prev_q & fs_s;
  // data bit is taken from the previous sample, one cycle before the edge seen, to honour short hold
  wire sclk_fall = sclk_prev_q & ~sclk_s;

  reg        active_q;
  reg [4:0]  bitcnt_q;
  reg [15:0] shift_q;
  reg        push_q;
  reg [15:0] push_word_q;
  wire       fifo_in_ready;
  wire [4:0] bitcnt_inc = bitcnt_q + 5'h01;
  wire [15:0] shift_nxt = {shift_q[14:0], din_prev_q};

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q    <= 1'b0;
      bitcnt_q    <= `QDAC_BITCNT_RST;
      shift_q     <= `QDAC_WORD_RST;
      push_q      <= 1'b0;
      push_word_q <= `QDAC_WORD_RST;
    end else begin
      push_q <= 1'b0;
      if (fs_fall) begin
        // the host lowers frame sync before the first clock edge, so a coincident edge is ignored
        active_q <= 1'b1;
        bitcnt_q <= `QDAC_BITCNT_RST;
        shift_q  <= `QDAC_WORD_RST;
      end else if (active_q && !selected) begin
        active_q <= 1'b0;
      end else if (active_q && sclk_fall) begin
        shift_q  <= shift_nxt;
        bitcnt_q <= bitcnt_inc;
        if (bitcnt_inc == `QDAC_BITCNT_LAST) begin
          active_q    <= 1'b0;
          push_q      <= 1'b1;
          push_word_q <= shift_nxt;
        end
      end else if (active_q && fs_rise) begin
        // early rise: partial word lands as shifted, right-aligned with its high bits zero
        active_q    <= 1'b0;
        push_q      <= (bitcnt_q != `QDAC_BITCNT_RST);
        push_word_q <= shift_q;
      end
    end
  end

  // word fifo decouples the serial side from the latch side; a full fifo drops the word
  assign word_overrun = push_q & ~fifo_in_ready;
  wire [15:0] fifo_word;
  wire        fifo_valid;
  wire        fifo_take;
  qdac_fifo #(
    .WIDTH (`QDAC_WORD_BITS),
    .DEPTH (`QDAC_FIFO_DEPTH),
    .AW    (`QDAC_FIFO_AW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_data   (push_word_q),
    .in_valid  (push_q),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );
  assign fifo_take = 1'b1;

  // input latches per channel, then output latches gated by load, except channel_powered, which follows power-down every cycle
  reg [11:0] code_q  [0:3];
  reg [3:0]  pwr_q;
  reg [3:0]  spd_q;
  wire [1:0] sel = {fifo_word[`QDAC_SEL_HI_POS], fifo_word[`QDAC_SEL_LO_POS]};
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          code_q[ch] <= `QDAC_CODE_RST;
          pwr_q[ch]  <= 1'b0;
          spd_q[ch]  <= 1'b0;
        end else if (fifo_valid && sel == ch) begin
          code_q[ch] <= fifo_word[`QDAC_CODE_MSB:0];
          pwr_q[ch]  <= fifo_word[`QDAC_PWR_POS];
          spd_q[ch]  <= fifo_word[`QDAC_SPD_POS];
        end
      end
    end
  endgenerate

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_a_output <= `QDAC_CODE_RST;
      channel_b_output <= `QDAC_CODE_RST;
      channel_c_output <= `QDAC_CODE_RST;
      channel_d_output <= `QDAC_CODE_RST;
      channel_powered  <= 4'h0;
      channel_fast     <= 4'h0;
    end else begin
      if (!load_n_s) begin
        channel_a_output <= code_q[0];
        channel_b_output <= code_q[1];
        channel_c_output <= code_q[2];
        channel_d_output <= code_q[3];
        channel_fast     <= spd_q;
      end
      channel_powered <= pd_n_s ? ~pwr_q : 4'h0;
    end
  end
endmodule

// file: include/qdac_regs.vh
// qdac_regs.vh: field positions, widths and reset values of the quad converter serial loader
// assumes it is included by its bare name from the rtl files
`ifndef QDAC_REGS_VH
`define QDAC_REGS_VH
`define QDAC_WORD_BITS      16
`define QDAC_CODE_BITS      12
`define QDAC_CODE_MSB       11
`define QDAC_SEL_LO_POS     12
`define QDAC_SEL_HI_POS     13
`define QDAC_PWR_POS        15
`define QDAC_SPD_POS        14
`define QDAC_CTRL_MSB       15
`define QDAC_BITCNT_LAST    5'h10
`define QDAC_BITCNT_RST     5'h00
`define QDAC_CODE_RST       12'h000
`define QDAC_WORD_RST       16'h0000
`define QDAC_FIFO_DEPTH     8
`define QDAC_FIFO_AW        3
`endif

// file: rtl/qdac_fifo.v
// qdac_fifo.v: small flip-flop FIFO with valid/ready on both sides
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/1ps
module qdac_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  genvar          i;
  localparam [AW:0] FULL_CNT = DEPTH;

  assign in_ready  = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
      localparam [AW-1:0] IDX = i;
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
          mem_q[i] <= {WIDTH{1'b0}};
        else if (push && wr_q == IDX)
          mem_q[i] <= in_data;
      end
    end
  endgenerate

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// file: test/qdac_properties.sv
// qdac_properties.sv: port checks of the quad converter loader
// assumes a bind onto qdac_serial_load
`timescale 1ns/1ps
module qdac_properties (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        chip_select_n,
  input wire        load_outputs_n,
  input wire        power_down_n,
  input wire [11:0] channel_a_output,
  input wire [11:0] channel_b_output,
  input wire [11:0] channel_c_output,
  input wire [11:0] channel_d_output,
  input wire [3:0]  channel_powered,
  input wire [3:0]  channel_fast,
  input wire        word_overrun
);
  wire [51:0] outs = {channel_fast, channel_d_output, channel_c_output, channel_b_output, channel_a_output};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_reset_clear: assert property ($rose(rst_n) |-> outs == 52'h0) else $error("not clear");
  a_hold_while_high: assert property (load_outputs_n [*4] |=> $stable(outs)) else $error("moved");
  // load passes through a two-flop sync and the output register, so the cause sits three cycles back
  a_update_needs_load: assert property (!$stable(outs) |->
    !($past(load_outputs_n, 2) && $past(load_outputs_n, 3))) else $error("no load");
  a_quiet_unselected: assert property ((chip_select_n && !load_outputs_n) [*8] |=>
    $stable(outs)) else $error("unselected");
  a_pd_unpowered: assert property (!power_down_n |-> ##[1:4] channel_powered == 4'h0) else $error("pd");
  a_pd_holds: assert property (!power_down_n [*5] |-> channel_powered == 4'h0) else $error("pd hold");
  a_power_needs_pin: assert property ($rose(|channel_powered) |-> $past(power_down_n, 3)) else $error("pin");
  a_no_overrun: assert property (!word_overrun) else $error("dropped");
endmodule

// file: test/qdac_host_model.sv
// qdac_host_model.sv: host serial port on the converter link
// assumes link edges are slow next to the block clock
`timescale 1ns/1ps
module qdac_host_model (
  output logic chip_select_n,
  output logic frame_sync,
  output logic serial_clk,
  output logic serial_data
);
  int half_ns = 100;
  // the link clock stands high between frames
  initial begin
    chip_select_n = 1'b0;
    frame_sync = 1'b1;
    serial_clk = 1'b1;
    serial_data = 1'b0;
  end
  // sends the top nbits of word; fewer than 16 ends the frame early
  task automatic send(input logic [15:0] word, input int nbits);
    frame_sync = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      serial_data = word[15-i];
      #(half_ns) serial_clk = 1'b0;
      #(half_ns) serial_clk = 1'b1;
    end
    #(half_ns) frame_sync = 1'b1;
    serial_data = ~serial_data;
  endtask
endmodule

// file: test/tb_top.sv
// tb_top.sv: self-checking bench for the quad converter loader
// assumes the host model owns the link except chip select, which the bench also drives, and the bench owns load, power-down and reset
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic load_outputs_n = 1'b0;
  logic power_down_n = 1'b1;
  wire chip_select_n, frame_sync, serial_clk, serial_data;
  wire [11:0] channel_a_output, channel_b_output, channel_c_output, channel_d_output;
  wire [3:0] channel_powered, channel_fast;
  wire [47:0] outs = {channel_d_output, channel_c_output, channel_b_output, channel_a_output};
  int errors = 0;
  int comparisons = 0;
  always #12.5 sys_clk = ~sys_clk;
  qdac_host_model host (.chip_select_n(chip_select_n), .frame_sync(frame_sync), .serial_clk(serial_clk),
    .serial_data(serial_data));
  qdac_serial_load dut (.sys_clk(sys_clk), .rst_n(rst_n), .chip_select_n(chip_select_n), .frame_sync(frame_sync),
    .serial_clk(serial_clk), .serial_data(serial_data), .load_outputs_n(load_outputs_n),
    .power_down_n(power_down_n), .channel_a_output(channel_a_output), .channel_b_output(channel_b_output),
    .channel_c_output(channel_c_output), .channel_d_output(channel_d_output),
    .channel_powered(channel_powered), .channel_fast(channel_fast), .word_overrun());
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // the update lands some six cycles after the last clock fall of a full word, or after frame sync rises on a short one
  task automatic write(input logic [15:0] word, input int nbits);
    host.send(word, nbits);
    repeat (12) @(negedge sys_clk);
  endtask
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("reset", outs[11:0] | outs[23:12] | outs[35:24] | outs[47:36], 12'h000);
    check("reset powered", {8'h00, channel_powered}, 12'h00F);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
      write({1'b0, i[0], i[1:0], 12'hA50 + i[11:0]}, 16);
    for (int i = 0; i < 4; i++)
      check("code", outs[i*12 +: 12], 12'hA50 + i[11:0]);
    check("fast", {8'h00, channel_fast}, 12'h00A);
    check("powered", {8'h00, channel_powered}, 12'h00F);
    $display("test channels done");
    load_outputs_n = 1'b1;
    write(16'h0123, 16);
    write(16'h1456, 16);
    check("hold a", channel_a_output, 12'hA50);
    check("hold b", channel_b_output, 12'hA51);
    load_outputs_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    check("load a", channel_a_output, 12'h123);
    check("load b", channel_b_output, 12'h456);
    $display("test load done");
    host.chip_select_n = 1'b1;
    write(16'h2FFF, 16);
    check("unselected", channel_c_output, 12'hA52);
    host.chip_select_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    write(16'h3A00, 8);
    check("short", channel_a_output, 12'h03A);
    $display("test select done");
    power_down_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    check("pd", {8'h00, channel_powered}, 12'h000);
    write(16'hB777, 16);
    power_down_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    check("pd off", {8'h00, channel_powered}, 12'h007);
    check("d", channel_d_output, 12'h777);
    $display("test power done");
    conclude();
  end
  initial begin
    #300000;
    errors++;
    conclude();
  end
endmodule
bind qdac_serial_load qdac_properties chk (.sys_clk(sys_clk), .rst_n(rst_n), .chip_select_n(chip_select_n),
  .load_outputs_n(load_outputs_n), .power_down_n(power_down_n), .channel_a_output(channel_a_output),
  .channel_b_output(channel_b_output), .channel_c_output(channel_c_output), .channel_d_output(channel_d_output),
  .channel_powered(channel_powered), .channel_fast(channel_fast), .word_overrun(word_overrun));
